// ==== core/tmr_consts.vh ====
// constants for the reloadable timer with capture and pwm
`ifndef TMR_CONSTS_VH
`define TMR_CONSTS_VH
// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define TMR_CNT_ADDR    8'h00
`define TMR_CMP_ADDR    8'h04
`define TMR_PWM_ADDR    8'h08
`define TMR_CAP_ADDR    8'h0c
`define TMR_CTRL_ADDR   8'h10
`define TMR_PRES_ADDR   8'h14
`define TMR_STAT_ADDR   8'h18
`define TMR_SWEV_ADDR   8'h1c
// ---------------------------------------------------------------
// control word fields, per half: a in [15:0], b in [31:16]
// ---------------------------------------------------------------
`define TMR_EN_BIT      0
`define TMR_MODE_LSB    1
`define TMR_MODE_W      3
`define TMR_POL_BIT     4
`define TMR_CLKSEL_LSB  5
`define TMR_CAPSEL_LSB  7
`define TMR_IE_BIT      9
`define TMR_WAKE_BIT    10
`define TMR_CASC_BIT    11
`define TMR_DUAL_BIT    12
`define TMR_CTRL_RST    32'h0000_0000
`define TMR_CNT_RST     32'h0000_0000
`define TMR_RELOAD      32'h0000_0001
`define TMR_CMP_RST     32'hffff_ffff
`define TMR_PRES_RST    32'h0001_0001
// ---------------------------------------------------------------
// mode codes
// ---------------------------------------------------------------
`define MODE_ONESHOT    3'h0
`define MODE_CONT       3'h1
`define MODE_COUNTER    3'h2
`define MODE_PWM        3'h3
`define MODE_CAPTURE    3'h4
`define MODE_COMPARE    3'h5
`define MODE_GATED      3'h6
`define MODE_CAPCMP     3'h7
`define PRES_MAX        13'h1000
`endif

// ==== core/tmr_prescaler.v ====
// prescaler producing a one-cycle count tick from a source enable
`timescale 1ns/1ns
module tmr_prescaler #(
   parameter W = 13
) (
   input  wire         ref_clk, // system clock
   input  wire         rst,     // sync reset, high
   input  wire         run,     // half enabled
   input  wire         src_tick,// selected source tick
   input  wire [W-1:0] div,     // division value, 0 read as 1
   output wire         tick     // count clock tick
);
   reg  [W-1:0] cnt_ff;
   wire [W-1:0] lim = (div == {W{1'b0}}) ? {W{1'b0}} : div - 1'b1;

   // divide source ticks by div; 1 passes every tick through
   always @(posedge ref_clk) begin
      if (rst || !run)
         cnt_ff <= {W{1'b0}};
      else if (src_tick)
         cnt_ff <= (cnt_ff >= lim) ? {W{1'b0}} : cnt_ff + 1'b1;
   end
   assign tick = run && src_tick && (cnt_ff >= lim);
endmodule // tmr_prescaler

// ==== core/tmr_half.v ====
// one timer half: count, mode logic, capture, output pin
`timescale 1ns/1ns
`include "tmr_consts.vh"
module tmr_half #(
   parameter W = 16
) (
   input  wire         ref_clk,  // system clock
   input  wire         rst,      // sync reset, high
   input  wire         en,       // half enabled
   input  wire [2:0]   mode,     // operating mode
   input  wire         pol,      // input active level / edge
   input  wire         tick,     // prescaled count tick
   input  wire         cap_in,   // selected capture source level
   input  wire         sw_ev,    // software capture event
   input  wire         pin_in,   // timer input pin
   input  wire [W-1:0] term,     // terminal value
   input  wire [W-1:0] pwm_th,   // pwm threshold
   input  wire [W-1:0] off_time, // pwm dead time in ticks
   input  wire         cnt_we,   // software count write
   input  wire [W-1:0] cnt_wd,   // count write data
   output reg  [W-1:0] cnt_ff,   // count
   output reg  [W-1:0] cap_ff,   // captured count
   output reg          out_ff,   // timer output / pwm main
   output reg          outn_ff,  // pwm complementary
   output wire         period    // one-cycle end of period
);
   reg pin_ff;   // pin latched on count tick
   reg cap_l_ff; // capture source latched on count tick
   reg stop_ff;  // one-shot halted
   wire pin_act = pin_ff ^ ~pol;
   wire pin_new = pin_in ^ ~pol;
   wire at_term = (cnt_ff >= term);
   wire cap_edge = tick && (cap_in != cap_l_ff) && (cap_in == pol);
   wire deassert = tick && pin_act && !pin_new;
   reg  adv;

   // input pin and capture source latched on the count clock
   always @(posedge ref_clk) begin
      if (rst) begin
         pin_ff   <= 1'b0;
         cap_l_ff <= 1'b0;
      end else if (tick) begin
         pin_ff   <= pin_in;
         cap_l_ff <= cap_in;
      end
   end

   // which mode lets the count move this cycle
   always @* begin
      case (mode)
         `MODE_COUNTER: adv = tick && pin_new && !pin_act;
         `MODE_GATED:   adv = tick && pin_act;
         `MODE_CAPCMP:  adv = tick && pin_act;
         `MODE_ONESHOT: adv = tick && !stop_ff;
         default:       adv = tick;
      endcase
   end
   assign period = en && adv && at_term;

   // count register: reload to one after the terminal value; one-shot holds at the terminal value
   always @(posedge ref_clk) begin
      if (rst) begin
         cnt_ff  <= {W{1'b0}};
         stop_ff <= 1'b0;
      end else if (cnt_we) begin
         cnt_ff  <= cnt_wd;
         stop_ff <= 1'b0;
      end else if (!en) begin
         stop_ff <= 1'b0;
      end else if (period) begin
         cnt_ff  <= (mode == `MODE_ONESHOT) ? cnt_ff : {{(W-1){1'b0}}, 1'b1};
         stop_ff <= (mode == `MODE_ONESHOT);
      end else if (adv) begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // capture, including software event which needs no tick
   always @(posedge ref_clk) begin
      if (rst)
         cap_ff <= {W{1'b0}};
      else if (en && mode == `MODE_CAPTURE && (cap_edge || sw_ev))
         cap_ff <= cnt_ff;
      else if (en && mode == `MODE_CAPCMP && deassert)
         // the last gated step lands on this edge; keep it in the snapshot
         cap_ff <= cnt_ff + {{(W-1){1'b0}}, adv};
   end

   // output pin: event toggle or non-overlapping pwm pair
   always @(posedge ref_clk) begin
      if (rst || !en) begin
         out_ff  <= 1'b0;
         outn_ff <= 1'b0;
      end else if (mode == `MODE_PWM) begin
         // dead band of off_time ticks either side of the threshold
         out_ff  <= (cnt_ff >= pwm_th + off_time);
         outn_ff <= (cnt_ff + off_time < pwm_th);
      end else if (period && (mode == `MODE_COMPARE || mode == `MODE_CONT
                              || mode == `MODE_ONESHOT)) begin
         out_ff  <= ~out_ff;
         outn_ff <= 1'b0;
      end
   end
endmodule // tmr_half

// ==== core/tmr_top.v ====
// reloadable timer: register port, clock select, cascade/dual halves
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "tmr_consts.vh"
module tmr_top #(
   parameter LOW_POWER = 0 // 1: single counter only, wake allowed
) (
   input  wire        ref_clk,   // system clock, 10 MHz
   input  wire        rst,       // sync reset, high
   input  wire [7:0]  addr,      // register byte address
   input  wire [31:0] wdata,     // write data
   input  wire        wr,        // write strobe
   input  wire        rd,        // read strobe
   output reg  [31:0] rdata_ff,  // read data, cycle after rd
   input  wire [3:0]  clk_src,   // four source ticks
   input  wire        pin_in,    // timer input pin
   input  wire [1:0]  sib_io,    // two sibling timer io signals
   output wire        pin_out,   // timer output pin
   output wire        pin_outn,  // complementary pwm output
   output wire        irq,       // interrupt, level
   output reg         wake_ff    // wake request to power control
);
   reg  [31:0] ctrl_ff, cmp_ff, pwm_ff, pres_ff, off_ff;
   reg  [1:0]  flag_ff;
   wire [31:0] cnt, cap;
   wire [1:0]  period, tk, out, outn;
   wire        casc = ctrl_ff[`TMR_CASC_BIT] && (LOW_POWER == 0);
   wire        dual = ctrl_ff[`TMR_DUAL_BIT] && (LOW_POWER == 0) && !casc;
   wire        wr_cnt = wr && addr == `TMR_CNT_ADDR;
   wire        sw_ev  = wr && addr == `TMR_SWEV_ADDR && LOW_POWER == 0;

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst) begin
         ctrl_ff <= `TMR_CTRL_RST;
         cmp_ff  <= `TMR_CMP_RST;
         pwm_ff  <= 32'h0000_0000;
         pres_ff <= `TMR_PRES_RST;
         off_ff  <= 32'h0000_0000;
      end else if (wr) begin
         case (addr)
            `TMR_CTRL_ADDR: ctrl_ff <= wdata;
            `TMR_CMP_ADDR:  cmp_ff  <= wdata;
            `TMR_PWM_ADDR:  pwm_ff  <= wdata;
            `TMR_PRES_ADDR: pres_ff <= wdata;
            `TMR_CAP_ADDR:  off_ff  <= wdata; // cap is read-only; write sets off-time
            default: ;
         endcase
      end
   end

   // sticky period flags; set beats write-one clear
   always @(posedge ref_clk) begin
      if (rst)
         flag_ff <= 2'b00;
      else
         flag_ff <= period | (flag_ff &
                    ~((wr && addr == `TMR_STAT_ADDR) ? wdata[1:0] : 2'b00));
   end
   assign irq = |(flag_ff & {ctrl_ff[16+`TMR_IE_BIT], ctrl_ff[`TMR_IE_BIT]});

   // wake request from a low-power instance with wake enabled while a period flag is set
   always @(posedge ref_clk) begin
      if (rst)
         wake_ff <= 1'b0;
      else
         wake_ff <= (LOW_POWER != 0) && ctrl_ff[`TMR_WAKE_BIT] && (|flag_ff);
   end

   // ---------------------------------------------------------------
   // read port
   // ---------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (rst)
         rdata_ff <= 32'h0000_0000;
      else if (rd) begin
         case (addr)
            `TMR_CNT_ADDR:  rdata_ff <= cnt;
            `TMR_CMP_ADDR:  rdata_ff <= cmp_ff;
            `TMR_PWM_ADDR:  rdata_ff <= pwm_ff;
            `TMR_CAP_ADDR:  rdata_ff <= cap;
            `TMR_CTRL_ADDR: rdata_ff <= ctrl_ff;
            `TMR_PRES_ADDR: rdata_ff <= pres_ff;
            `TMR_STAT_ADDR: rdata_ff <= {30'h0, flag_ff};
            default:        rdata_ff <= 32'h0000_0000; // unmapped reads zero
         endcase
      end else
         rdata_ff <= 32'h0000_0000;
   end

   // ---------------------------------------------------------------
   // two halves; in cascade the upper half steps on lower period
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : half
         wire [15:0] c = ctrl_ff[16*g +: 16];
         wire        hen = (g == 0) ? c[`TMR_EN_BIT]
                         : (casc ? ctrl_ff[`TMR_EN_BIT] : (dual && c[`TMR_EN_BIT]));
         wire [1:0]  cs = casc ? ctrl_ff[`TMR_CLKSEL_LSB +: 2] : c[`TMR_CLKSEL_LSB +: 2];
         wire [1:0]  ks = c[`TMR_CAPSEL_LSB +: 2];
         wire [3:0]  cap_srcs = {1'b0, sib_io, pin_in};
         wire        ptick;
         tmr_prescaler #(.W(13)) u_pres (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .run      (hen),
            .src_tick (clk_src[cs]),
            .div      (pres_ff[16*g +: 13]),
            .tick     (ptick)
         );
         assign tk[g] = (g == 1 && casc) ? period[0] : ptick;
         tmr_half #(.W(16)) u_half (
            .ref_clk  (ref_clk),
            .rst      (rst),
            .en       (hen),
            .mode     (casc ? ctrl_ff[`TMR_MODE_LSB +: 3] : c[`TMR_MODE_LSB +: 3]),
            .pol      (c[`TMR_POL_BIT]),
            .tick     (tk[g]),
            .cap_in   (cap_srcs[ks]),
            .sw_ev    (sw_ev && ks == 2'd3),
            .pin_in   (pin_in),
            .term     (cmp_ff[16*g +: 16]),
            .pwm_th   (pwm_ff[16*g +: 16]),
            .off_time (off_ff[16*g +: 16]),
            .cnt_we   (wr_cnt),
            .cnt_wd   (wdata[16*g +: 16]),
            .cnt_ff   (cnt[16*g +: 16]),
            .cap_ff   (cap[16*g +: 16]),
            .out_ff   (out[g]),
            .outn_ff  (outn[g]),
            .period   (period[g])
         );
      end
   endgenerate

   // output pin follows lower half; upper half output in dual mode
   assign pin_out  = out[0] | (dual & out[1]);
   assign pin_outn = outn[0];
endmodule // tmr_top

// ==== tb/tmr_top_chk.sv ====
// assertion checker for the timer register port, pins and interrupt
`timescale 1ns/1ns
module tmr_top_chk #(
   parameter LOW_POWER = 0
) (
   input wire        ref_clk,  // system clock
   input wire        rst,      // sync reset, high
   input wire [7:0]  addr,     // register address
   input wire [31:0] wdata,    // write data
   input wire        wr,       // write strobe
   input wire        rd,       // read strobe
   input wire [31:0] rdata_ff, // read data
   input wire        pin_out,  // timer output
   input wire        pin_outn, // complementary output
   input wire        irq,      // interrupt level
   input wire        wake_ff   // wake request
);
   // shadows kept from writes; either half may raise the flags
   reg [31:0] cmp_ff;
   reg        ie_ff;
   reg        en_ff;
   always @(posedge ref_clk) begin
      if (rst) begin
         cmp_ff <= 32'hffff_ffff;
         ie_ff  <= 1'b0;
         en_ff  <= 1'b0;
      end else if (wr && addr == 8'h10) begin
         ie_ff <= wdata[9] | wdata[25];
         en_ff <= wdata[0] | wdata[16];
      end else if (wr && addr == 8'h04) begin
         cmp_ff <= wdata;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   rdata_idle_a: assert property (!rd |=> rdata_ff == 32'h0)
      else $error("read data not zero outside a read");
   unmapped_read_a: assert property (rd && addr > 8'h1c |=> rdata_ff == 32'h0)
      else $error("unmapped read returned data");
   terminal_read_a: assert property (rd && addr == 8'h04 |=> rdata_ff == cmp_ff)
      else $error("terminal value read back wrong");
   pwm_overlap_a: assert property (!(pin_out && pin_outn))
      else $error("pwm outputs overlap");
   wake_quiet_a: assert property (LOW_POWER != 0 || !wake_ff)
      else $error("wake request from standard instance");
   irq_enable_a: assert property (irq |-> ie_ff)
      else $error("interrupt without enable");
   irq_clear_a: assert property ($fell(irq) |-> $past(wr))
      else $error("interrupt dropped without a write");
   irq_cause_a: assert property ($rose(irq) |-> $past(en_ff) || $past(wr))
      else $error("interrupt raised while stopped");
   cover property ($rose(irq));
   cover property (pin_outn);
   cover property (rd && addr == 8'h0c);
endmodule // tmr_top_chk
bind tmr_top tmr_top_chk #(.LOW_POWER(LOW_POWER)) u_tmr_top_chk (
   .ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
   .rdata_ff(rdata_ff), .pin_out(pin_out), .pin_outn(pin_outn), .irq(irq),
   .wake_ff(wake_ff));

// ==== tb/tmr_pin_model.sv ====
// far side model: input pin pulse bursts, sibling ios and source ticks
`timescale 1ns/1ns
module tmr_pin_model (
   input  wire       ref_clk, // system clock
   input  wire       rst,     // sync reset, high
   input  wire       go,      // start a burst
   input  wire [3:0] n_pulse, // pulses in the burst
   output reg        pin_in,  // timer input pin
   output reg  [1:0] sib_io,  // sibling io levels
   output wire [3:0] clk_src, // source ticks
   output wire       busy     // burst running
);
   reg [3:0] left;
   reg [1:0] ph;
   reg [2:0] div;
   // sources tick every cycle, every 2nd, 4th and 8th
   assign clk_src = {div == 3'h0, div[1:0] == 2'h0, div[0], 1'b1};
   assign busy = left != 4'h0;
   // pulses two cycles high, two low; pin changes off the count clock phase
   always @(posedge ref_clk) begin
      if (rst) begin
         left   <= 4'h0;
         ph     <= 2'h0;
         div    <= 3'h0;
         pin_in <= 1'b0;
         sib_io <= 2'h0;
      end else begin
         div    <= div + 3'h1;
         sib_io <= div[2:1];
         if (go) begin
            left <= n_pulse;
            ph   <= 2'h0;
         end else if (busy) begin
            ph <= ph + 2'h1;
            if (ph == 2'h3)
               left <= left - 4'h1;
         end
         pin_in <= busy && !go && !ph[1];
      end
   end
endmodule // tmr_pin_model

// ==== tb/tb_tmr_top.sv ====
// self-checking bench for the reloadable timer
`timescale 1ns/1ns
module tb_tmr_top;
   reg         ref_clk, rst, wr, rd, go;
   reg  [7:0]  addr;
   reg  [31:0] wdata, v, w;
   reg  [3:0]  n_pulse;
   wire [31:0] rdata_ff;
   wire [3:0]  clk_src;
   wire [1:0]  sib_io;
   wire        pin_in, pin_out, pin_outn, irq, wake_ff, busy;
   integer     miscompares, checks, i, h, hn, tg;
   tmr_top u_tmr_top (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata_ff(rdata_ff), .clk_src(clk_src), .pin_in(pin_in),
      .sib_io(sib_io), .pin_out(pin_out), .pin_outn(pin_outn), .irq(irq),
      .wake_ff(wake_ff));
   tmr_pin_model u_tmr_pin_model (.ref_clk(ref_clk), .rst(rst), .go(go),
      .n_pulse(n_pulse), .pin_in(pin_in), .sib_io(sib_io), .clk_src(clk_src),
      .busy(busy));
   // ------------------------------------------------------------
   // bus tasks, compare and verdict
   // ------------------------------------------------------------
   task complete_run;
      begin
         $display("checks %0d miscompares %0d", checks, miscompares);
         if (miscompares == 0 && checks > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   task chk(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
      begin
         checks = checks + 1;
         if (got !== exp) begin
            $display("ERROR %0s expected %h seen %h", name, exp, got);
            miscompares = miscompares + 1;
         end
      end
   endtask
   task wr_reg(input [7:0] a, input [31:0] d);
      begin
         @(posedge ref_clk);
         addr  <= a;
         wdata <= d;
         wr    <= 1'b1;
         @(posedge ref_clk);
         wr <= 1'b0;
      end
   endtask
   // read data stand only in the cycle after the strobe
   task rd_reg(input [7:0] a, output [31:0] d);
      begin
         @(posedge ref_clk);
         addr <= a;
         rd   <= 1'b1;
         @(posedge ref_clk);
         rd <= 1'b0;
         #1 d = rdata_ff;
      end
   endtask
   // stop, load terminal and count, then start with the new control word
   task setup(input [31:0] cmp, input [31:0] cnt, input [31:0] ctrl);
      begin
         wr_reg(8'h10, 32'h0);
         wr_reg(8'h04, cmp);
         wr_reg(8'h00, cnt);
         wr_reg(8'h10, ctrl);
      end
   endtask
   task pulses(input [3:0] n);
      begin
         @(posedge ref_clk);
         go      <= 1'b1;
         n_pulse <= n;
         @(posedge ref_clk);
         go <= 1'b0;
         // busy only rises once the model has taken go
         @(posedge ref_clk);
         for (i = 0; i < 100 && busy; i = i + 1)
            @(posedge ref_clk);
         if (busy) begin
            miscompares = miscompares + 1;
            complete_run;
         end
         repeat (4) @(posedge ref_clk);
      end
   endtask
   // high cycles of both outputs and toggles of the main one over 40 cycles
   task obs;
      begin
         h = 0;
         hn = 0;
         tg = 0;
         // start from the level now on the pin, not a stale one
         #1 w[0] = pin_out;
         repeat (40) begin
            @(posedge ref_clk);
            #1 h = h + pin_out;
            hn = hn + pin_outn;
            tg = tg + (pin_out != w[0]);
            w[0] = pin_out;
         end
      end
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      {rst, wr, rd, go, addr, wdata, n_pulse, w} = {1'b1, 79'h0};
      miscompares = 0;
      checks = 0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      rd_reg(8'h00, v); chk("cnt_rst", 32'h0, v);
      rd_reg(8'h04, v); chk("cmp_rst", 32'hffff_ffff, v);
      rd_reg(8'h10, v); chk("ctrl_rst", 32'h0, v);
      rd_reg(8'h20, v); chk("unmapped", 32'h0, v);
      setup(32'h5, 32'h1, 32'h201);
      repeat (20) @(posedge ref_clk);
      rd_reg(8'h00, v); chk("oneshot_end", 32'h5, v);
      repeat (5) @(posedge ref_clk);
      rd_reg(8'h00, w); chk("oneshot", 32'h5, w);
      chk("irq_set", 32'h1, {31'h0, irq});
      wr_reg(8'h18, 32'h1);
      #1 chk("irq_clr", 32'h0, {31'h0, irq});
      wr_reg(8'h14, 32'h4);
      setup(32'hffff, 32'h1, 32'h3);
      rd_reg(8'h00, v);
      repeat (38) @(posedge ref_clk);
      rd_reg(8'h00, w); chk("prescale", 32'd10, w - v);
      wr_reg(8'h14, 32'h1);
      setup(32'h3, 32'h1, 32'h3);
      repeat (5) begin
         rd_reg(8'h00, v); chk("cont_range", 32'h1, {31'h0, v >= 1 && v <= 3});
      end
      setup(32'hffff, 32'h0, 32'h15);
      pulses(4'd5);
      rd_reg(8'h00, v); chk("counter", 32'd5, v);
      setup(32'hffff, 32'h7, 32'h1d);
      repeat (10) @(posedge ref_clk);
      rd_reg(8'h00, v); chk("gate_hold", 32'h7, v);
      pulses(4'd3);
      rd_reg(8'h00, v); chk("gate_run", 32'd13, v);
      setup(32'hffff, 32'h1, 32'h1f);
      pulses(4'd1);
      rd_reg(8'h00, v); chk("capcmp_cnt", 32'h3, v);
      rd_reg(8'h0c, w); chk("capcmp", 32'h3, w);
      setup(32'hffff, 32'h1, 32'h199);
      wr_reg(8'h1c, 32'h1);
      wr_reg(8'h10, 32'h0);
      rd_reg(8'h0c, v); chk("sw_capture", 32'h2, v);
      wr_reg(8'h08, 32'd10);
      wr_reg(8'h0c, 32'd2);
      setup(32'd20, 32'h1, 32'h7);
      repeat (6) @(posedge ref_clk);
      obs;
      chk("pwm_hi", 32'd18, h);
      chk("pwm_lo", 32'd14, hn);
      setup(32'h4, 32'h1, 32'hb);
      repeat (6) @(posedge ref_clk);
      obs;
      chk("cmp_toggle", 32'd10, tg);
      complete_run;
   end
endmodule // tb_tmr_top
